// File: hw/fdx_pkg.sv
// Shared types and constants of the floppy transfer command executor.
package fdx_pkg;
   typedef enum logic [2:0] {
      OP_RD_DEL = 3'h0,
      OP_RD_TRK = 3'h1,
      OP_WR = 3'h2,
      OP_WR_DEL = 3'h3,
      OP_VERIFY = 3'h4,
      OP_FORMAT = 3'h5
   } fdx_op_e;
   typedef enum logic [7:0] {
      S_IDLE = 8'h01,
      S_HLOAD = 8'h02,
      S_INDEX = 8'h04,
      S_SEARCH = 8'h08,
      S_MARK = 8'h10,
      S_READ = 8'h20,
      S_WRITE = 8'h40,
      S_DONE = 8'h80
   } fdx_state_e;
   typedef enum logic [2:0] {
      PH_GAP = 3'h0,
      PH_IDM = 3'h1,
      PH_ID = 3'h2,
      PH_DAM = 3'h3,
      PH_DATA = 3'h4,
      PH_CRC1 = 3'h5,
      PH_CRC2 = 3'h6
   } fdx_phase_e;
   typedef struct packed {logic [7:0] c; logic [7:0] h; logic [7:0] r; logic [7:0] n;} fdx_id_s;
   // The byte_length field also carries sector_total for verify.
   typedef struct packed {
      fdx_op_e op;
      logic two_side_flag;
      logic bypass_deleted_flag;
      logic count_stop_flag;
      logic mfm;
      fdx_id_s id;
      logic [7:0] last_sector_id;
      logic [7:0] gap_length;
      logic [7:0] byte_length;
      logic [7:0] fill_pattern_byte;
      logic [7:0] sectors_per_side;
   } fdx_cmd_s;
   typedef struct packed {logic [7:0] status_zero; logic [7:0] st1; logic [7:0] st2; fdx_id_s id;} fdx_res_s;
   typedef struct packed {
      fdx_state_e st;
      fdx_phase_e ph;
      fdx_cmd_s cmd;
      fdx_id_s cur;
      logic [1:0] idx;
      logic id_seen;
      logic in_id;
      logic skip;
      logic halt;
      logic stop;
      logic [14:0] cnt;
      logic [7:0] total;
      logic [7:0] secs;
      logic [7:0] s0;
      logic [7:0] s1;
      logic [7:0] s2;
      logic [15:0] crc;
      logic rd_v;
      logic [7:0] rd_d;
      logic wv;
      logic wmark;
      logic [7:0] wb;
      logic done;
      fdx_res_s res;
   } fdx_state_s;
   localparam int IC_LSB = 6;
   localparam logic [1:0] IC_ABNORMAL = 2'h1;
   localparam int ST0_HEAD = 2;
   localparam int ST1_NO_ID = 0;
   localparam int ST1_ABSENT = 2;
   localparam int ST1_CRC = 5;
   localparam int ST2_ID_CRC = 5;
   localparam int ST2_CM = 6;
   localparam logic [14:0] SECT_BASE = 15'h0080;
   localparam logic [7:0] GAP_MFM = 8'h4E;
   localparam logic [7:0] GAP_FM = 8'hFF;
   localparam logic [7:0] MARK_ID = 8'hFE;
   localparam logic [7:0] MARK_DATA = 8'hFB;
   localparam logic [7:0] MARK_DEL = 8'hF8;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [7:0] FIRST_SECTOR = 8'h01;
endpackage

// File: hw/fdx_exec.sv
// Execution engine for the floppy data transfer and format commands.
`timescale 1ns/10ps
module fdx_exec
   import fdx_pkg::*;
(
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic clk_en_in,
   input wire logic start_in,
   input wire fdx_cmd_s cmd_in,
   input wire logic head_ready_in,
   output logic head_load_out,
   input wire logic index_pulse_in,
   input wire logic id_found_in,
   input wire fdx_id_s id_in,
   input wire logic id_crc_ok_in,
   input wire logic dam_found_in,
   input wire logic dam_deleted_in,
   input wire logic rd_valid_in,
   input wire logic [7:0] rd_byte_in,
   input wire logic rd_end_in,
   input wire logic rd_crc_ok_in,
   output logic host_rd_valid_out,
   output logic [7:0] host_rd_data_out,
   input wire logic host_wr_valid_in,
   input wire logic [7:0] host_wr_data_in,
   output logic host_wr_take_out,
   input wire logic fifo_fault_in,
   input wire logic count_end_input_in,
   input wire logic wr_req_in,
   output logic wr_valid_out,
   output logic wr_mark_out,
   output logic [7:0] wr_byte_out,
   output logic busy_out,
   output logic done_out,
   output fdx_res_s result_out
);
   fdx_state_s s;
   fdx_state_s next_s;
   logic take;
   logic [14:0] size;
   logic [14:0] lim;
   logic is_wr;

   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] x;
      x = c;
      for (int i = 7; i >= 0; i--) begin
         x = (x[15] ^ d[i]) ? ({x[14:0], 1'b0} ^ CRC_POLY) : {x[14:0], 1'b0};
      end
      return x;
   endfunction

   // Closes one sector: advances the address unless halt is set, and decides whether to go on.
   function automatic fdx_state_s sector_done(input fdx_state_s a);
      fdx_state_s b;
      logic end_trk;
      logic fin;
      b = a;
      end_trk = 1'b0;
      fin = a.stop || a.halt;
      b.secs = a.secs + 8'h01;
      b.total = a.total - 8'h01;
      if (!a.halt) begin
         if (a.cur.r == a.cmd.last_sector_id) begin
            b.cur.r = FIRST_SECTOR;
            if (a.cmd.two_side_flag && !a.cur.h[0]) begin
               b.cur.h[0] = 1'b1;
            end else begin
               b.cur.c = a.cur.c + 8'h01;
               b.cur.h[0] = a.cur.h[0] ^ a.cmd.two_side_flag;
               end_trk = 1'b1;
            end
         end else begin
            b.cur.r = a.cur.r + 8'h01;
         end
      end
      if (a.cmd.op == OP_RD_TRK) begin
         fin = fin || (b.secs == a.cmd.last_sector_id);
      end
      if (a.cmd.op == OP_VERIFY && a.cmd.count_stop_flag) begin
         fin = fin || (b.total == 8'h00);
         if (end_trk && b.total != 8'h00) begin
            b.s0[IC_LSB+:2] = IC_ABNORMAL;
         end
      end
      b.st = (fin || end_trk) ? S_DONE : S_SEARCH;
      b.idx = 2'h0;
      b.id_seen = 1'b0;
      b.halt = 1'b0;
      return b;
   endfunction

   assign size = 15'(SECT_BASE << s.cmd.id.n[2:0]);
   assign lim = (s.cmd.id.n == 8'h00) ? {7'h00, s.cmd.byte_length} : size;
   assign is_wr = (s.cmd.op == OP_WR) || (s.cmd.op == OP_WR_DEL);

   always_comb begin
      next_s = s;
      next_s.done = 1'b0;
      next_s.rd_v = 1'b0;
      next_s.wv = 1'b0;
      next_s.wmark = 1'b0;
      take = 1'b0;
      if (s.st != S_IDLE && (count_end_input_in || fifo_fault_in)) begin
         next_s.stop = 1'b1;
      end
      unique case (s.st)
         S_IDLE: begin
            if (start_in) begin
               next_s = '0;
               next_s.cmd = cmd_in;
               next_s.cur = cmd_in.id;
               next_s.total = cmd_in.byte_length;
               next_s.res = s.res;
               next_s.st = S_HLOAD;
               if (cmd_in.op == OP_VERIFY && cmd_in.count_stop_flag &&
                   cmd_in.last_sector_id > cmd_in.sectors_per_side) begin
                  next_s.s0[IC_LSB+:2] = IC_ABNORMAL;
                  next_s.st = S_DONE;
               end
            end
         end
         S_HLOAD: begin
            if (head_ready_in) begin
               next_s.st = (s.cmd.op == OP_FORMAT || s.cmd.op == OP_RD_TRK) ? S_INDEX : S_SEARCH;
            end
         end
         S_INDEX: begin
            if (index_pulse_in) begin
               next_s.st = (s.cmd.op == OP_FORMAT) ? S_WRITE : S_SEARCH;
               next_s.ph = PH_GAP;
               next_s.cnt = 15'h0000;
            end
         end
         S_SEARCH: begin
            if (index_pulse_in) begin
               next_s.idx = s.idx + 2'h1;
               if (s.idx == 2'h1) begin
                  next_s.s0[IC_LSB+:2] = IC_ABNORMAL;
                  next_s.s1[ST1_NO_ID] = !s.id_seen;
                  next_s.s1[ST1_ABSENT] = s.id_seen;
                  next_s.st = S_DONE;
               end
            end else if (id_found_in) begin
               next_s.id_seen = 1'b1;
               if (!id_crc_ok_in) begin
                  next_s.s1[ST1_CRC] = 1'b1;
                  next_s.s2[ST2_ID_CRC] = !is_wr;
                  if (s.cmd.op == OP_RD_TRK) begin
                     next_s.st = S_MARK;
                  end else begin
                     next_s.s0[IC_LSB+:2] = IC_ABNORMAL;
                     next_s.st = S_DONE;
                  end
               end else if (s.cmd.op == OP_RD_TRK) begin
                  next_s.s1[ST1_ABSENT] = s.s1[ST1_ABSENT] | (id_in != s.cur);
                  next_s.st = S_MARK;
               end else if (id_in == s.cur) begin
                  next_s.st = is_wr ? S_WRITE : S_MARK;
                  next_s.ph = PH_DAM;
               end
            end
         end
         S_MARK: begin
            if (dam_found_in) begin
               next_s.st = S_READ;
               next_s.cnt = 15'h0000;
               next_s.skip = 1'b0;
               if (s.cmd.op == OP_RD_DEL && !dam_deleted_in) begin
                  next_s.s2[ST2_CM] = 1'b1;
                  next_s.skip = s.cmd.bypass_deleted_flag;
                  next_s.halt = !s.cmd.bypass_deleted_flag;
               end
            end
         end
         S_READ: begin
            if (rd_valid_in) begin
               next_s.cnt = s.cnt + 15'h0001;
               // Verify consumes the field but never hands it to the host.
               if (!s.skip && s.cmd.op != OP_VERIFY && !s.stop && s.cnt < lim) begin
                  next_s.rd_v = 1'b1;
                  next_s.rd_d = rd_byte_in;
               end
            end
            if (rd_end_in) begin
               if (!rd_crc_ok_in && !s.skip) begin
                  next_s.s1[ST1_CRC] = 1'b1;
               end
               if (!rd_crc_ok_in && !s.skip && s.cmd.op != OP_RD_TRK) begin
                  next_s.s0[IC_LSB+:2] = IC_ABNORMAL;
                  next_s.st = S_DONE;
               end else begin
                  next_s = sector_done(next_s);
               end
            end
         end
         S_WRITE: begin
            if (s.cmd.op == OP_FORMAT && index_pulse_in) begin
               next_s.st = S_DONE;
            end else if (wr_req_in) begin
               next_s.wv = 1'b1;
               next_s.cnt = s.cnt + 15'h0001;
               unique case (s.ph)
                  PH_GAP: begin
                     next_s.wb = s.cmd.mfm ? GAP_MFM : GAP_FM;
                     if (s.cnt + 15'h0001 >= {7'h00, s.cmd.gap_length}) begin
                        next_s.ph = PH_IDM;
                     end
                  end
                  PH_IDM: begin
                     next_s.wmark = 1'b1;
                     next_s.wb = MARK_ID;
                     next_s.crc = crc_step(CRC_INIT, MARK_ID);
                     next_s.ph = PH_ID;
                     next_s.cnt = 15'h0000;
                  end
                  PH_ID: begin
                     // A late host byte simply holds the ID field back.
                     next_s.wv = host_wr_valid_in;
                     take = host_wr_valid_in;
                     next_s.wb = host_wr_data_in;
                     next_s.crc = host_wr_valid_in ? crc_step(s.crc, host_wr_data_in) : s.crc;
                     next_s.cnt = host_wr_valid_in ? s.cnt + 15'h0001 : s.cnt;
                     next_s.in_id = 1'b1;
                     if (host_wr_valid_in && s.cnt == 15'h0003) begin
                        next_s.ph = PH_CRC1;
                     end
                  end
                  PH_DAM: begin
                     next_s.wmark = 1'b1;
                     next_s.wb = (s.cmd.op == OP_WR_DEL) ? MARK_DEL : MARK_DATA;
                     next_s.crc = crc_step(CRC_INIT, next_s.wb);
                     next_s.ph = PH_DATA;
                     next_s.cnt = 15'h0000;
                  end
                  PH_DATA: begin
                     if (s.cmd.op == OP_FORMAT) begin
                        next_s.wb = s.cmd.fill_pattern_byte;
                     end else if (!s.stop && !count_end_input_in && s.cnt < lim &&
                                  host_wr_valid_in) begin
                        take = 1'b1;
                        next_s.wb = host_wr_data_in;
                     end else begin
                        next_s.wb = 8'h00;
                        next_s.stop = s.stop | count_end_input_in | (s.cnt < lim);
                     end
                     next_s.crc = crc_step(s.crc, next_s.wb);
                     if (s.cnt + 15'h0001 == size) begin
                        next_s.ph = PH_CRC1;
                     end
                  end
                  PH_CRC1: begin
                     next_s.wb = s.crc[15:8];
                     next_s.ph = PH_CRC2;
                  end
                  default: begin
                     next_s.wb = s.crc[7:0];
                     next_s.cnt = 15'h0000;
                     next_s.in_id = 1'b0;
                     if (s.cmd.op == OP_FORMAT) begin
                        next_s.ph = s.in_id ? PH_DAM : PH_GAP;
                     end else begin
                        next_s = sector_done(next_s);
                     end
                  end
               endcase
            end
         end
         S_DONE: begin
            next_s.res.status_zero = s.s0 | {5'h00, s.cur.h[0], 2'h0};
            next_s.res.st1 = s.s1;
            next_s.res.st2 = s.s2;
            next_s.res.id = s.cur;
            next_s.done = 1'b1;
            next_s.st = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         s <= '0;
         s.st <= S_IDLE;
      end else if (clk_en_in) begin
         s <= next_s;
      end
   end

   assign head_load_out = (s.st != S_IDLE);
   assign busy_out = (s.st != S_IDLE);
   assign host_rd_valid_out = s.rd_v;
   assign host_rd_data_out = s.rd_d;
   assign host_wr_take_out = take && clk_en_in;
   assign wr_valid_out = s.wv;
   assign wr_mark_out = s.wmark;
   assign wr_byte_out = s.wb;
   assign done_out = s.done;
   assign result_out = s.res;

   cm_flag_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      clk_en_in && s.st == S_MARK && s.cmd.op == OP_RD_DEL && dam_found_in && !dam_deleted_in
      |=> s.s2[ST2_CM] && s.st == S_READ) else $error("Control mark not flagged.");
   skip_quiet_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      clk_en_in && s.st == S_READ && s.skip |=> !host_rd_valid_out)
      else $error("Skipped sector reached the host.");
   addr_next_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      clk_en_in && s.st == S_READ && rd_end_in && rd_crc_ok_in && !s.halt && !s.stop &&
      s.cur.r != s.cmd.last_sector_id |=> s.cur.r == $past(s.cur.r) + 8'h01)
      else $error("Sector number not advanced.");
   eot_wrap_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      clk_en_in && s.st == S_READ && rd_end_in && rd_crc_ok_in && !s.halt &&
      s.cur.r == s.cmd.last_sector_id |=> s.cur.r == FIRST_SECTOR)
      else $error("Sector number not reset at end of track.");
   no_id_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      clk_en_in && s.st == S_SEARCH && index_pulse_in && s.idx == 2'h1 && !s.id_seen
      |=> s.s1[ST1_NO_ID] && s.s0[IC_LSB+:2] == IC_ABNORMAL ##1 done_out)
      else $error("Missing ID mark not reported.");
   zero_pad_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      clk_en_in && s.st == S_WRITE && s.ph == PH_DATA && s.stop && wr_req_in &&
      s.cmd.op != OP_FORMAT && !index_pulse_in |=> wr_valid_out && wr_byte_out == 8'h00)
      else $error("Field not padded with zeros.");
   wr_id_crc_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      clk_en_in && s.st == S_SEARCH && is_wr && id_found_in && !id_crc_ok_in && !index_pulse_in
      |=> s.s1[ST1_CRC] && s.st == S_DONE) else $error("ID CRC error not ending write.");
   verify_quiet_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      s.st == S_READ && s.cmd.op == OP_VERIFY |-> !host_rd_valid_out)
      else $error("Verify passed data to the host.");
   fmt_end_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      clk_en_in && s.st == S_WRITE && s.cmd.op == OP_FORMAT && index_pulse_in
      |=> s.st == S_DONE ##1 done_out) else $error("Format did not end at index.");
   done_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      clk_en_in && s.st == S_DONE |=> done_out && !busy_out)
      else $error("Completion not signalled.");
endmodule

// File: tb/fdx_drive.sv
// Drive and media model: index pulses, ID fields, data fields and write byte requests.
`timescale 1ns/10ps
module fdx_drive
   import fdx_pkg::*;
(
   input wire logic clock_in,
   input wire logic head_load_in,
   output logic head_ready_out,
   output logic index_out,
   output logic id_found_out,
   output fdx_id_s id_out,
   output logic id_ok_out,
   output logic dam_out,
   output logic dam_del_out,
   output logic rd_valid_out,
   output logic [7:0] rd_byte_out,
   output logic rd_end_out,
   output logic rd_ok_out,
   output logic wr_req_out
);
   int settle = 3;
   int lc = 0;
   initial begin
      {index_out, id_found_out, dam_out, rd_valid_out, rd_end_out, wr_req_out} = '0;
      {id_ok_out, dam_del_out, rd_ok_out, head_ready_out} = '0;
      id_out = '0;
      rd_byte_out = 8'h00;
   end
   // The head reports ready only after the load request has stood for more than settle cycles.
   always @(negedge clock_in) begin
      lc = head_load_in ? lc + 1 : 0;
      head_ready_out <= lc > settle;
   end
   // Released data lines turn over at each release, so a stale value never looks fresh.
   task automatic idle();
      @(negedge clock_in);
      {index_out, id_found_out, dam_out, rd_valid_out, rd_end_out, wr_req_out} = '0;
      rd_byte_out = ~rd_byte_out;
      id_out = ~id_out;
   endtask
   task automatic ready();
      while (!head_ready_out) @(negedge clock_in);
      @(negedge clock_in);
   endtask
   task automatic index();
      ready();
      index_out = 1'b1;
      idle();
   endtask
   task automatic id_field(input fdx_id_s id, input logic ok);
      ready();
      id_found_out = 1'b1;
      id_out = id;
      id_ok_out = ok;
      idle();
   endtask
   task automatic data_field(input logic del, input logic ok);
      ready();
      dam_out = 1'b1;
      dam_del_out = del;
      idle();
      // The media always delivers the whole 128-byte field, whatever the host takes.
      for (int i = 0; i < 128; i++) begin
         @(negedge clock_in);
         rd_valid_out = 1'b1;
         rd_byte_out = 8'h11 + 8'(i);
         idle();
      end
      @(negedge clock_in);
      rd_end_out = 1'b1;
      rd_ok_out = ok;
      idle();
   endtask
   task automatic reqs(input int n);
      repeat (n) begin
         @(negedge clock_in);
         wr_req_out = 1'b1;
         idle();
      end
   endtask
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the transfer command executor.
`timescale 1ns/10ps
module tb_top
   import fdx_pkg::*;
();
   logic clock_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic start_in = 1'b0;
   logic hwv = 1'b0;
   logic cnt_end = 1'b0;
   logic clk_en = 1'b1;
   logic ffault = 1'b0;
   logic [7:0] hwd = 8'h5A;
   fdx_cmd_s cmd = '0;
   logic hl, hr, ix, idf, idok, dam, damd, rv, re, rok, wrq, hrv, take, wv, wm, busy, done;
   fdx_id_s idv;
   logic [7:0] rb, hrd, wb, hlast;
   fdx_res_s result, res;
   logic [8:0] wq[$];
   int num_errors = 0;
   int num_checks = 0;
   int nrd = 0, ntake = 0, ndone = 0, n0 = 0, cyc = 0, nz;
   always #12.5 clock_in = ~clock_in;
   fdx_exec dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en),
      .start_in(start_in), .cmd_in(cmd), .head_ready_in(hr), .head_load_out(hl),
      .index_pulse_in(ix), .id_found_in(idf), .id_in(idv), .id_crc_ok_in(idok),
      .dam_found_in(dam), .dam_deleted_in(damd), .rd_valid_in(rv), .rd_byte_in(rb),
      .rd_end_in(re), .rd_crc_ok_in(rok), .host_rd_valid_out(hrv), .host_rd_data_out(hrd),
      .host_wr_valid_in(hwv), .host_wr_data_in(hwd), .host_wr_take_out(take),
      .fifo_fault_in(ffault), .count_end_input_in(cnt_end), .wr_req_in(wrq),
      .wr_valid_out(wv), .wr_mark_out(wm), .wr_byte_out(wb), .busy_out(busy),
      .done_out(done), .result_out(result));
   fdx_drive drv (.clock_in(clock_in), .head_load_in(hl), .head_ready_out(hr),
      .index_out(ix), .id_found_out(idf), .id_out(idv), .id_ok_out(idok), .dam_out(dam),
      .dam_del_out(damd), .rd_valid_out(rv), .rd_byte_out(rb), .rd_end_out(re),
      .rd_ok_out(rok), .wr_req_out(wrq));
   // Sampling just before the rising edge sees exactly what the design acts on.
   always @(negedge clock_in) begin
      #11;
      cyc++;
      if (hrv) nrd++;
      if (hrv) hlast = hrd;
      if (take) ntake++;
      if (wv) wq.push_back({wm, wb});
      if (done) res = result;
      if (done) ndone++;
      if (cyc == 20000) begin
         num_errors++;
         summarize();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("checks=%0d errors=%0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic base(input logic [7:0] r);
      cmd = '0;
      cmd.mfm = 1'b1;
      cmd.id = '{8'h05, 8'h00, r, 8'h00};
      cmd.last_sector_id = 8'h09;
      cmd.gap_length = 8'h04;
      cmd.byte_length = 8'h04;
      cmd.fill_pattern_byte = 8'hE5;
      cmd.sectors_per_side = 8'h09;
   endtask
   task automatic go(input fdx_op_e op);
      @(negedge clock_in);
      wq.delete();
      nrd = 0;
      ntake = 0;
      n0 = ndone;
      cmd.op = op;
      start_in = 1'b1;
      @(negedge clock_in);
      start_in = 1'b0;
   endtask
   task automatic wait_done();
      for (int i = 0; i < 3000 && ndone == n0; i++) @(negedge clock_in);
      chk(16'(ndone - n0), 16'h0001);
   endtask
   task automatic secs(input int first, input int n, input logic del);
      for (int s = first; s < first + n; s++) begin
         drv.id_field('{cmd.id.c, cmd.id.h, 8'(s), cmd.id.n}, 1'b1);
         drv.data_field(del, 1'b1);
      end
   endtask
   task automatic chk_res(input logic [7:0] c, input logic [7:0] h, input logic [7:0] r);
      chk(16'({res.id.c, res.id.h}), {c, h});
      chk(16'(res.id.r), 16'(r));
   endtask
   function automatic logic [15:0] crc_of(input int n);
      logic [15:0] c;
      c = CRC_INIT;
      for (int i = 0; i < n; i++) begin
         c = c ^ {wq[i][7:0], 8'h00};
         for (int b = 0; b < 8; b++) c = c[15] ? (c << 1) ^ CRC_POLY : c << 1;
      end
      return c;
   endfunction
   initial begin
      repeat (3) @(negedge clock_in);
      sys_rst_in = 1'b0;
      for (int k = 0; k < 4; k++) begin
         base(8'h09);
         cmd.two_side_flag = k[1];
         cmd.id.h = 8'(k[0]);
         go(OP_RD_DEL);
         // A terminal count after the host bytes is what ends a two-side read on side zero.
         fork
            secs(9, 1, 1'b1);
            begin
               wait (nrd == 4);
               @(negedge clock_in);
               cnt_end = 1'b1;
               @(negedge clock_in);
               cnt_end = 1'b0;
            end
         join
         wait_done();
         chk(16'(nrd), 16'h0004);
         chk(16'(hlast), 16'h0014);
         chk(16'(res.st2[ST2_CM]), 16'h0000);
         chk_res((k == 2) ? 8'h05 : 8'h06, 8'(k[0] ^ k[1]), 8'h01);
      end
      base(8'h08);
      go(OP_RD_DEL);
      secs(8, 2, 1'b1);
      wait_done();
      chk(16'(nrd), 16'h0008);
      chk_res(8'h06, 8'h00, 8'h01);
      for (int sk = 0; sk < 2; sk++) begin
         base((sk == 1) ? 8'h09 : 8'h03);
         cmd.bypass_deleted_flag = sk[0];
         go(OP_RD_DEL);
         secs((sk == 1) ? 9 : 3, 1, 1'b0);
         wait_done();
         chk(16'(nrd), (sk == 1) ? 16'h0000 : 16'h0004);
         chk(16'(res.st2[ST2_CM]), 16'h0001);
         if (sk == 0) chk_res(8'h05, 8'h00, 8'h03);
      end
      base(8'h01);
      go(OP_RD_DEL);
      drv.index();
      drv.index();
      wait_done();
      chk(16'(res.status_zero[7:6]), 16'(IC_ABNORMAL));
      chk(16'(res.st1[ST1_NO_ID]), 16'h0001);
      hwv = 1'b1;
      base(8'h09);
      cmd.byte_length = 8'h10;
      go(OP_WR);
      drv.id_field(cmd.id, 1'b1);
      drv.reqs(131);
      wait_done();
      chk(16'(wq.size()), 16'h0083);
      chk(16'(wq[0]), {7'h00, 1'b1, MARK_DATA});
      chk(16'(wq[16]), 16'h005A);
      chk(16'(wq[17]), 16'h0000);
      chk({wq[129][7:0], wq[130][7:0]}, crc_of(129));
      chk_res(8'h06, 8'h00, 8'h01);
      // First pass stops the field by terminal count, second by a FIFO fault.
      for (int f = 0; f < 2; f++) begin
         base(8'h09);
         cmd.byte_length = 8'h40;
         go(OP_WR_DEL);
         drv.id_field(cmd.id, 1'b1);
         drv.reqs(12);
         @(negedge clock_in);
         {ffault, cnt_end} = f[0] ? 2'b10 : 2'b01;
         @(negedge clock_in);
         {ffault, cnt_end} = 2'b00;
         drv.reqs(119);
         wait_done();
         nz = 0;
         foreach (wq[i]) if (i > 0 && i < 129 && wq[i] !== 9'h000) nz++;
         chk(16'(wq[0]), {7'h00, 1'b1, MARK_DEL});
         chk(16'(nz), 16'(ntake));
         chk(16'(ntake), 16'h000B);
      end
      base(8'h09);
      go(OP_WR);
      drv.id_field(cmd.id, 1'b0);
      wait_done();
      chk(16'(res.status_zero[7:6]), 16'(IC_ABNORMAL));
      chk(16'(res.st1[ST1_CRC]), 16'h0001);
      chk(16'(wq.size()), 16'h0000);
      base(8'h01);
      cmd.count_stop_flag = 1'b1;
      cmd.byte_length = 8'h02;
      go(OP_VERIFY);
      secs(1, 2, 1'b0);
      wait_done();
      chk(16'(nrd), 16'h0000);
      chk_res(8'h05, 8'h00, 8'h03);
      cmd.last_sector_id = 8'h0A;
      // With the enable low a start must be ignored and nothing may complete.
      clk_en = 1'b0;
      go(OP_VERIFY);
      repeat (2) @(negedge clock_in);
      chk(16'(busy), 16'h0000);
      chk(16'(ndone - n0), 16'h0000);
      clk_en = 1'b1;
      go(OP_VERIFY);
      wait_done();
      chk(16'(res.status_zero[7:6]), 16'(IC_ABNORMAL));
      base(8'h01);
      cmd.byte_length = 8'hFF;
      cmd.last_sector_id = 8'h02;
      go(OP_VERIFY);
      secs(1, 2, 1'b0);
      wait_done();
      chk_res(8'h06, 8'h00, 8'h01);
      base(8'h01);
      cmd.last_sector_id = 8'h02;
      go(OP_RD_TRK);
      drv.index();
      drv.id_field(cmd.id, 1'b1);
      drv.data_field(1'b0, 1'b0);
      drv.id_field('{8'h05, 8'h00, 8'h07, 8'h00}, 1'b1);
      drv.data_field(1'b0, 1'b1);
      wait_done();
      chk(16'(nrd), 16'h0008);
      chk(16'(res.st1[ST1_CRC]), 16'h0001);
      chk(16'(res.st1[ST1_ABSENT]), 16'h0001);
      base(8'h01);
      hwd = 8'h03;
      go(OP_FORMAT);
      drv.index();
      drv.reqs(150);
      drv.index();
      wait_done();
      chk(16'(wq[3]), 16'h004E);
      chk(16'(wq[4]), {7'h00, 1'b1, MARK_ID});
      chk(16'(wq[11]), {7'h00, 1'b1, MARK_DATA});
      chk(16'(wq[12]), 16'h00E5);
      chk(16'(ntake), 16'h0007);
      chk(16'(wq[7]), 16'h0003);
      summarize();
   end
endmodule
